/* File: design/ecfx_defs.vh */
// constants for the channel control configuration bank
`ifndef ECFX_DEFS_VH
`define ECFX_DEFS_VH

// register offsets (byte addresses on the 8-bit register port)
`define ECFX_ADDR_IDLE_CFG      8'h32
`define ECFX_ADDR_IDLE_MASK     8'h33
`define ECFX_ADDR_IDLE_PAT      8'h34
`define ECFX_ADDR_FRAME_CFG     8'h60
`define ECFX_ADDR_PIN_MASK      8'h6b
`define ECFX_ADDR_PIN_ACT       8'h6c
`define ECFX_ADDR_FBIT_ACT      8'h6d
`define ECFX_ADDR_MON_SEL       8'h6f
`define ECFX_ADDR_IDLE_STAT0    8'h70

// reset values
`define ECFX_RST_IDLE_CFG       6'h1d
`define ECFX_RST_IDLE_MASK      8'h00
`define ECFX_RST_IDLE_PAT       8'h55
`define ECFX_RST_FRAME_CFG      7'h00
`define ECFX_RST_PIN_MASK       6'h3f
`define ECFX_RST_PIN_ACT        6'h00
`define ECFX_RST_FBIT_ACT       6'h00
`define ECFX_RST_MON_SEL        8'hfe

// action field positions, shared by pin and frame-bit action registers
`define ECFX_ACT_CONV           0
`define ECFX_ACT_COEFF          1
`define ECFX_ACT_METER          2
`define ECFX_ACT_FREEZE         3
`define ECFX_ACT_NLP            4
`define ECFX_ACT_BYPASS         5

// idle configuration field positions
`define ECFX_IDLE_SRC           0
`define ECFX_IDLE_MODE          1
`define ECFX_IDLE_IV_LO         2
`define ECFX_IDLE_IV_HI         4
`define ECFX_IDLE_EN            5

// frame bit selector and pin mask positions
`define ECFX_FSEL_LO            2
`define ECFX_FSEL_HI            3
`define ECFX_PMASK_FLEX         0

// monitor codes with internal sources
`define ECFX_MON_IDLE           4'h0
`define ECFX_MON_RI_TEST        4'hc
`define ECFX_MON_SI_TEST        4'hd

// protection intervals in milliseconds, and the frame period in microseconds
`define ECFX_IV0_MS             64
`define ECFX_IV1_MS             128
`define ECFX_IV2_MS             512
`define ECFX_IV3_MS             1000
`define ECFX_IV4_MS             4100
`define ECFX_IV5_MS             8200
`define ECFX_IV6_MS             32800
`define ECFX_IV7_MS             65500
`define ECFX_FRAME_US           125

`endif

/* File: design/ecfx_ctrl.v */
// per-channel control mapping, monitor selection and idle detection for the echo canceller
`timescale 1ns/1ns
`default_nettype none
`include "ecfx_defs.vh"

module ecfx_ctrl #(
    parameter NCHAN = 32,
    parameter CHW = 5,
    parameter FRAME_US = `ECFX_FRAME_US
) (
    input wire I_REF_CLK,
    input wire I_ARST_N,
    // register port
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [7:0] O_RDATA,
    // per-sample channel stream
    input wire I_SAMPLE_VALID,
    input wire [CHW-1:0] I_CHAN,
    input wire [7:0] I_RECV_IN,
    input wire [7:0] I_SEND_IN,
    input wire [2:0] I_CTRL_FRAME_BITS,
    input wire I_FLEX_CONTROL_PIN,
    input wire I_HOST_ONLY_CONTROL,
    input wire I_HOST_DISABLE,
    input wire I_HOST_NLP_OFF,
    input wire I_HOST_FREEZE,
    input wire I_HOST_CONV_DISABLE,
    // monitor sources of the current time slot
    input wire [CHW-1:0] I_SLOT,
    input wire [CHW-1:0] I_TEST_CHANNEL_SELECT,
    input wire I_RECV_IN_TEST_STREAM,
    input wire I_SEND_IN_TEST_STREAM,
    input wire [15:0] I_DETECT,
    // per-channel control results
    output reg O_CTRL_VALID,
    output reg [CHW-1:0] O_CTRL_CHAN,
    output reg O_BYPASS,
    output reg O_NLP_OFF,
    output reg O_FREEZE,
    output reg O_METER_RESET,
    output reg O_COEFF_RESET,
    output reg O_CONV_DISABLE,
    output reg O_IDLE,
    // flexible monitor pins
    output reg O_MONITOR_PIN_A,
    output reg O_MONITOR_PIN_B
);

    // frame counts for each protection interval
    localparam [19:0] IV0 = (`ECFX_IV0_MS * 1000) / FRAME_US;
    localparam [19:0] IV1 = (`ECFX_IV1_MS * 1000) / FRAME_US;
    localparam [19:0] IV2 = (`ECFX_IV2_MS * 1000) / FRAME_US;
    localparam [19:0] IV3 = (`ECFX_IV3_MS * 1000) / FRAME_US;
    localparam [19:0] IV4 = (`ECFX_IV4_MS * 1000) / FRAME_US;
    localparam [19:0] IV5 = (`ECFX_IV5_MS * 1000) / FRAME_US;
    localparam [19:0] IV6 = (`ECFX_IV6_MS * 1000) / FRAME_US;
    localparam [19:0] IV7 = (`ECFX_IV7_MS * 1000) / FRAME_US;
    localparam NSTAT = (NCHAN + 7) / 8;

    // configuration registers
    // write protection is not modelled: every configuration register is writable at any time
    reg [5:0] idle_detect_config;
    reg [7:0] idle_compare_mask;
    reg [7:0] idle_compare_pattern;
    reg [6:0] frame_cfg;
    reg [5:0] flex_pin_mask;
    reg [5:0] pin_action_config;
    reg [5:0] frame_bit_action_config;
    reg [7:0] monitor_pin_select;

    // per-channel idle state
    reg [19:0] idle_timer [0:NCHAN-1];
    reg [7:0] last_sample [0:NCHAN-1];
    reg [NCHAN-1:0] idle_status_flag;

    // frame count of the selected protection interval, minus one
    // minus one because the matching sample that reaches the limit sets the flag
    function [19:0] iv_limit;
        input [2:0] code;
        begin
            case (code)
                3'h0: iv_limit = IV0 - 20'h00001;
                3'h1: iv_limit = IV1 - 20'h00001;
                3'h2: iv_limit = IV2 - 20'h00001;
                3'h3: iv_limit = IV3 - 20'h00001;
                3'h4: iv_limit = IV4 - 20'h00001;
                3'h5: iv_limit = IV5 - 20'h00001;
                3'h6: iv_limit = IV6 - 20'h00001;
                default: iv_limit = IV7 - 20'h00001;
            endcase
        end
    endfunction

    // one monitor pin level from a four-bit code
    // codes without an internal source take the detector bit of the same number
    function mon_pick;
        input [3:0] code;
        input [15:0] src;
        begin
            mon_pick = src[code];
        end
    endfunction

    // field decode
    wire idle_en = idle_detect_config[`ECFX_IDLE_EN];
    wire idle_mode = idle_detect_config[`ECFX_IDLE_MODE];
    wire idle_src = idle_detect_config[`ECFX_IDLE_SRC];
    wire [2:0] idle_interval_code = idle_detect_config[`ECFX_IDLE_IV_HI:`ECFX_IDLE_IV_LO];
    wire [1:0] frame_bit_selector = frame_cfg[`ECFX_FSEL_HI:`ECFX_FSEL_LO];
    wire [3:0] monitor_a_code = monitor_pin_select[7:4];
    wire [3:0] monitor_b_code = monitor_pin_select[3:0];

    // register writes
    always @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            idle_detect_config <= `ECFX_RST_IDLE_CFG;
            idle_compare_mask <= `ECFX_RST_IDLE_MASK;
            idle_compare_pattern <= `ECFX_RST_IDLE_PAT;
            frame_cfg <= `ECFX_RST_FRAME_CFG;
            flex_pin_mask <= `ECFX_RST_PIN_MASK;
            pin_action_config <= `ECFX_RST_PIN_ACT;
            frame_bit_action_config <= `ECFX_RST_FBIT_ACT;
            monitor_pin_select <= `ECFX_RST_MON_SEL;
        end
        else if (I_WR)
        begin
            case (I_ADDR)
                `ECFX_ADDR_IDLE_CFG: idle_detect_config <= I_WDATA[5:0];
                `ECFX_ADDR_IDLE_MASK: idle_compare_mask <= I_WDATA;
                `ECFX_ADDR_IDLE_PAT: idle_compare_pattern <= I_WDATA;
                `ECFX_ADDR_FRAME_CFG: frame_cfg <= I_WDATA[6:0];
                `ECFX_ADDR_PIN_MASK: flex_pin_mask <= I_WDATA[5:0];
                `ECFX_ADDR_PIN_ACT: pin_action_config <= I_WDATA[5:0];
                `ECFX_ADDR_FBIT_ACT: frame_bit_action_config <= I_WDATA[5:0];
                `ECFX_ADDR_MON_SEL: monitor_pin_select <= I_WDATA;
                default: ;
            endcase
        end
    end

    // read mux; idle flags of eight channels per status byte
    // status bytes are read only; writes to them fall into the default branch
    reg [7:0] next_rdata;
    integer s;
    always @*
    begin
        next_rdata = 8'h00;
        case (I_ADDR)
            `ECFX_ADDR_IDLE_CFG: next_rdata = {2'b00, idle_detect_config};
            `ECFX_ADDR_IDLE_MASK: next_rdata = idle_compare_mask;
            `ECFX_ADDR_IDLE_PAT: next_rdata = idle_compare_pattern;
            `ECFX_ADDR_FRAME_CFG: next_rdata = {1'b0, frame_cfg};
            `ECFX_ADDR_PIN_MASK: next_rdata = {2'b00, flex_pin_mask};
            `ECFX_ADDR_PIN_ACT: next_rdata = {2'b00, pin_action_config};
            `ECFX_ADDR_FBIT_ACT: next_rdata = {2'b00, frame_bit_action_config};
            `ECFX_ADDR_MON_SEL: next_rdata = monitor_pin_select;
            default:
            begin
                for (s = 0; s < NSTAT; s = s + 1)
                begin
                    if (I_ADDR == `ECFX_ADDR_IDLE_STAT0 + s[7:0])
                        next_rdata = stat_byte(s);
                end
            end
        endcase
    end

    function [7:0] stat_byte;
        input integer idx;
        integer b;
        begin
            stat_byte = 8'h00;
            for (b = 0; b < 8; b = b + 1)
            begin
                if (idx * 8 + b < NCHAN)
                    stat_byte[b] = idle_status_flag[idx * 8 + b];
            end
        end
    endfunction

    always @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_RDATA <= 8'h00;
        else if (I_RD)
            O_RDATA <= next_rdata;
        // data stand one cycle, so an old answer is never taken for a new one
        else
            O_RDATA <= 8'h00;
    end

    // flexible frame bit from the channel control frame
    reg flexible_frame_bit;
    always @*
    begin
        case (frame_bit_selector)
            2'b11: flexible_frame_bit = I_CTRL_FRAME_BITS[2];
            2'b10: flexible_frame_bit = I_CTRL_FRAME_BITS[1];
            2'b01: flexible_frame_bit = I_CTRL_FRAME_BITS[0];
            // selector 00 leaves the frame bit unused
            default: flexible_frame_bit = 1'b0;
        endcase
    end

    // flexible pin counts only while unmasked
    wire flexible_control_pin = I_FLEX_CONTROL_PIN & ~flex_pin_mask[`ECFX_PMASK_FLEX];

    // per-action enables from frame bit and pin
    wire [5:0] fx_act = {6{flexible_frame_bit}} & frame_bit_action_config;
    wire [5:0] fp_act = {6{flexible_control_pin}} & pin_action_config;

    // idle detection on the current sample
    wire [7:0] cmp_sample = idle_src ? I_SEND_IN : I_RECV_IN;
    wire [7:0] cmp_ref = idle_mode ? last_sample[I_CHAN] : idle_compare_pattern;
    wire cmp_match = ((cmp_sample ^ cmp_ref) & ~idle_compare_mask) == 8'h00;
    wire [19:0] cur_timer = idle_timer[I_CHAN];
    wire cur_idle = idle_status_flag[I_CHAN];

    integer c;
    always @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            idle_status_flag <= {NCHAN{1'b0}};
            for (c = 0; c < NCHAN; c = c + 1)
            begin
                idle_timer[c] <= 20'h00000;
                last_sample[c] <= 8'h00;
            end
        end
        else if (I_SAMPLE_VALID)
        begin
            // kept even with detection off, so comparison mode starts from real data
            last_sample[I_CHAN] <= cmp_sample;
            if (!idle_en)
            begin
                // detection inactive: nothing accumulates
                idle_timer[I_CHAN] <= 20'h00000;
                idle_status_flag[I_CHAN] <= 1'b0;
            end
            else if (!cmp_match)
            begin
                idle_timer[I_CHAN] <= 20'h00000;
                idle_status_flag[I_CHAN] <= 1'b0;
            end
            // the timer stops at the limit; the flag holds while samples keep matching
            else if (cur_timer >= iv_limit(idle_interval_code))
                idle_status_flag[I_CHAN] <= 1'b1;
            else
                idle_timer[I_CHAN] <= cur_timer + 20'h00001;
        end
    end

    // idle of the current channel as a control source, taken before this sample's update
    wire idle_src_act = idle_en & cur_idle;

    // hardware sources combined per action
    wire hw_bypass = fx_act[`ECFX_ACT_BYPASS] | fp_act[`ECFX_ACT_BYPASS] | idle_src_act;
    wire hw_nlp = fx_act[`ECFX_ACT_NLP] | fp_act[`ECFX_ACT_NLP];
    wire hw_freeze = fx_act[`ECFX_ACT_FREEZE] | fp_act[`ECFX_ACT_FREEZE];
    wire hw_meter = fx_act[`ECFX_ACT_METER] | fp_act[`ECFX_ACT_METER] | idle_src_act;
    wire hw_coeff = fx_act[`ECFX_ACT_COEFF] | fp_act[`ECFX_ACT_COEFF] | idle_src_act;
    wire hw_conv = fx_act[`ECFX_ACT_CONV] | fp_act[`ECFX_ACT_CONV];

    // host bit ored with the hardware source; host-only control drops the hardware side
    function ctl_merge;
        input host_bit;
        input hw_bit;
        input host_only;
        begin
            ctl_merge = host_bit | (~host_only & hw_bit);
        end
    endfunction

    wire next_bypass = ctl_merge(I_HOST_DISABLE, hw_bypass, I_HOST_ONLY_CONTROL);
    wire next_nlp = ctl_merge(I_HOST_NLP_OFF, hw_nlp, I_HOST_ONLY_CONTROL);
    wire next_freeze = ctl_merge(I_HOST_FREEZE, hw_freeze, I_HOST_ONLY_CONTROL);
    wire next_meter = ctl_merge(I_HOST_DISABLE, hw_meter, I_HOST_ONLY_CONTROL);
    wire next_coeff = ctl_merge(I_HOST_DISABLE, hw_coeff, I_HOST_ONLY_CONTROL);
    wire next_conv = ctl_merge(I_HOST_CONV_DISABLE, hw_conv, I_HOST_ONLY_CONTROL);

    always @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_CTRL_VALID <= 1'b0;
            O_CTRL_CHAN <= {CHW{1'b0}};
            O_BYPASS <= 1'b0;
            O_NLP_OFF <= 1'b0;
            O_FREEZE <= 1'b0;
            O_METER_RESET <= 1'b0;
            O_COEFF_RESET <= 1'b0;
            O_CONV_DISABLE <= 1'b0;
            O_IDLE <= 1'b0;
        end
        else
        begin
            O_CTRL_VALID <= I_SAMPLE_VALID;
            if (I_SAMPLE_VALID)
            begin
                O_CTRL_CHAN <= I_CHAN;
                O_BYPASS <= next_bypass;
                O_NLP_OFF <= next_nlp;
                O_FREEZE <= next_freeze;
                O_METER_RESET <= next_meter;
                O_COEFF_RESET <= next_coeff;
                O_CONV_DISABLE <= next_conv;
                O_IDLE <= cur_idle;
            end
        end
    end

    // monitor source vector for the current time slot
    // test streams read zero outside the chosen test slot
    wire test_slot = (I_SLOT == I_TEST_CHANNEL_SELECT);
    wire [15:0] mon_src = {
        I_DETECT[15:14],
        I_SEND_IN_TEST_STREAM & test_slot,
        I_RECV_IN_TEST_STREAM & test_slot,
        I_DETECT[11:8],
        I_DETECT[7:4],
        I_DETECT[3:1],
        idle_status_flag[I_SLOT]
    };

    always @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_MONITOR_PIN_A <= 1'b0;
            O_MONITOR_PIN_B <= 1'b0;
        end
        else
        begin
            O_MONITOR_PIN_A <= mon_pick(monitor_a_code, mon_src);
            O_MONITOR_PIN_B <= mon_pick(monitor_b_code, mon_src);
        end
    end

endmodule
`default_nettype wire

/* File: bench/ecfx_ctrl_monitor.sv */
// concurrent checks on the ports of the channel control bank
`timescale 1ns/1ns
`default_nettype none
module ecfx_ctrl_monitor #(
    parameter CHW = 5
) (
    input wire I_REF_CLK,
    input wire I_ARST_N,
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    input wire [7:0] O_RDATA,
    input wire I_SAMPLE_VALID,
    input wire [CHW-1:0] I_CHAN,
    input wire I_HOST_ONLY_CONTROL,
    input wire I_HOST_DISABLE,
    input wire I_HOST_NLP_OFF,
    input wire I_HOST_FREEZE,
    input wire I_HOST_CONV_DISABLE,
    input wire [15:0] I_DETECT,
    input wire O_CTRL_VALID,
    input wire [CHW-1:0] O_CTRL_CHAN,
    input wire O_BYPASS,
    input wire O_NLP_OFF,
    input wire O_FREEZE,
    input wire O_METER_RESET,
    input wire O_COEFF_RESET,
    input wire O_CONV_DISABLE,
    input wire O_IDLE,
    input wire O_MONITOR_PIN_A,
    input wire O_MONITOR_PIN_B
);
    logic [7:0] mon_sel;
    logic ready;
    wire [5:0] ctl = {O_BYPASS, O_NLP_OFF, O_FREEZE, O_METER_RESET, O_COEFF_RESET, O_CONV_DISABLE};
    wire host_any = I_HOST_DISABLE | I_HOST_NLP_OFF | I_HOST_FREEZE | I_HOST_CONV_DISABLE;
    // shadow of the monitor selection, written at the same edge as the bank
    always @(posedge I_REF_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            mon_sel <= 8'hfe;
            ready <= 1'b0;
        end
        else
        begin
            ready <= 1'b1;
            if (I_WR && I_ADDR == 8'h6f)
                mon_sel <= I_WDATA;
        end
    end
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);
    a_rdata_quiet: assert property (O_RDATA != 8'h00 |-> $past(I_RD))
        else $error("read data outside the read answer cycle");
    a_ctrl_answer: assert property (ready && I_SAMPLE_VALID |=>
        O_CTRL_VALID && O_CTRL_CHAN == $past(I_CHAN))
        else $error("control answer missing or wrong channel");
    a_ctrl_single: assert property (ready && !I_SAMPLE_VALID |=> !O_CTRL_VALID)
        else $error("control valid without a sample");
    a_ctrl_hold: assert property (ready && !I_SAMPLE_VALID |=> $stable({ctl, O_IDLE}))
        else $error("control outputs changed without a sample");
    a_host_disable: assert property (ready && I_SAMPLE_VALID && I_HOST_DISABLE |=>
        O_BYPASS && O_METER_RESET && O_COEFF_RESET)
        else $error("host disable not applied");
    a_host_bits: assert property (ready && I_SAMPLE_VALID |=>
        (O_NLP_OFF >= $past(I_HOST_NLP_OFF)) && (O_FREEZE >= $past(I_HOST_FREEZE))
        && (O_CONV_DISABLE >= $past(I_HOST_CONV_DISABLE)))
        else $error("host control bit not ored in");
    a_host_only: assert property (ready && I_SAMPLE_VALID && I_HOST_ONLY_CONTROL && !host_any
        |=> ctl == 6'h00)
        else $error("hardware source active under host-only control");
    a_mon_pin_a: assert property (ready && !(mon_sel[7:4] inside {4'h0, 4'hc, 4'hd}) |=>
        O_MONITOR_PIN_A == $past(I_DETECT[mon_sel[7:4]]))
        else $error("monitor pin a does not follow its code");
    a_mon_pin_b: assert property (ready && !(mon_sel[3:0] inside {4'h0, 4'hc, 4'hd}) |=>
        O_MONITOR_PIN_B == $past(I_DETECT[mon_sel[3:0]]))
        else $error("monitor pin b does not follow its code");
endmodule
`default_nettype wire

/* File: bench/ecfx_tb.sv */
// self-checking bench for the channel control bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int FRAME_US = 32000;
    localparam int IDLE_N = 64000 / FRAME_US;
    localparam int IDLE_N1 = 128000 / FRAME_US;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic sv = 1'b0;
    logic [4:0] chan = 5'h00;
    logic [7:0] recv = 8'h00;
    logic [2:0] fb = 3'h0;
    logic pin = 1'b0;
    logic [4:0] host = 5'h00;
    logic [4:0] tsel = 5'h01;
    logic ri = 1'b1;
    logic si = 1'b1;
    logic [15:0] det = 16'h0000;
    int mismatches = 0;
    int cmp_count = 0;
    wire [7:0] rdata;
    wire [4:0] cchan;
    wire [5:0] ctl;
    wire cv, idle, mon_a, mon_b;
    always #4 clk = ~clk;
    ecfx_ctrl #(.NCHAN(32), .CHW(5), .FRAME_US(FRAME_US)) DUT (
        .I_REF_CLK(clk), .I_ARST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_SAMPLE_VALID(sv), .I_CHAN(chan),
        .I_RECV_IN(recv), .I_SEND_IN(8'h00), .I_CTRL_FRAME_BITS(fb), .I_FLEX_CONTROL_PIN(pin),
        .I_HOST_ONLY_CONTROL(host[4]), .I_HOST_DISABLE(host[3]), .I_HOST_NLP_OFF(host[2]),
        .I_HOST_FREEZE(host[1]), .I_HOST_CONV_DISABLE(host[0]), .I_SLOT(5'h01),
        .I_TEST_CHANNEL_SELECT(tsel), .I_RECV_IN_TEST_STREAM(ri), .I_SEND_IN_TEST_STREAM(si),
        .I_DETECT(det), .O_CTRL_VALID(cv), .O_CTRL_CHAN(cchan), .O_BYPASS(ctl[5]),
        .O_NLP_OFF(ctl[4]), .O_FREEZE(ctl[3]), .O_METER_RESET(ctl[2]), .O_COEFF_RESET(ctl[1]),
        .O_CONV_DISABLE(ctl[0]), .O_IDLE(idle), .O_MONITOR_PIN_A(mon_a), .O_MONITOR_PIN_B(mon_b));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // one sample in, then the control answer of the next cycle
    task automatic smp(input logic [2:0] f, input logic p, input logic [4:0] h,
                       input logic [7:0] r, input logic [5:0] e, input logic ei);
        @(posedge clk);
        sv <= 1'b1;
        chan <= 5'h01;
        fb <= f;
        pin <= p;
        host <= h;
        recv <= r;
        @(posedge clk);
        sv <= 1'b0;
        #1 chk(8'(cv), 8'h01);
        chk(8'(ctl), 8'(e));
        chk(8'(idle), 8'(ei));
    endtask
    task automatic t_regs;
        rdchk(8'h32, 8'h1d);
        rdchk(8'h33, 8'h00);
        rdchk(8'h34, 8'h55);
        rdchk(8'h6d, 8'h00);
        rdchk(8'h6f, 8'hfe);
        wr(8'h34, 8'h3c);
        rdchk(8'h34, 8'h3c);
        wr(8'h01, 8'hff);
        rdchk(8'h01, 8'h00);
        wr(8'h6d, 8'hff);
        rdchk(8'h6d, 8'h3f);
        $display("register test done");
    endtask
    task automatic t_actions;
        int sel;
        logic [5:0] hexp [4] = '{6'h26, 6'h10, 6'h08, 6'h01};
        wr(8'h32, 8'h00);
        wr(8'h6c, 8'h3f);
        // pin is masked at reset, so only the selected frame bit acts
        for (int b = 0; b < 6; b++)
        begin
            sel = 1 + b % 3;
            wr(8'h60, 8'(sel << 2));
            wr(8'h6d, 8'(1 << b));
            smp(3'(1 << (sel - 1)), 1'b1, 5'h00, 8'h00, 6'(1 << b), 1'b0);
            smp(~3'(1 << (sel - 1)), 1'b1, 5'h00, 8'h00, 6'h00, 1'b0);
        end
        wr(8'h6d, 8'h00);
        wr(8'h6b, 8'h3e);
        wr(8'h6c, 8'h02);
        smp(3'h0, 1'b1, 5'h00, 8'h00, 6'h02, 1'b0);
        smp(3'h0, 1'b0, 5'h00, 8'h00, 6'h00, 1'b0);
        wr(8'h6c, 8'h01);
        smp(3'h0, 1'b1, 5'h00, 8'h00, 6'h01, 1'b0);
        wr(8'h6d, 8'h21);
        smp(3'h4, 1'b0, 5'h00, 8'h00, 6'h21, 1'b0);
        smp(3'h4, 1'b1, 5'h10, 8'h00, 6'h00, 1'b0);
        for (int i = 0; i < 4; i++)
            smp(3'h4, 1'b1, 5'h10 | 5'(8 >> i), 8'h00, hexp[i], 1'b0);
        $display("action test done");
    endtask
    task automatic t_idle;
        wr(8'h33, 8'h01);
        wr(8'h32, 8'h20);
        for (int i = 0; i <= IDLE_N; i++)
            smp(3'h0, 1'b0, 5'h00, 8'h3d, i == IDLE_N ? 6'h26 : 6'h00, i == IDLE_N);
        // switch to the send input, which differs from the pattern
        wr(8'h32, 8'h21);
        smp(3'h0, 1'b0, 5'h00, 8'h3d, 6'h26, 1'b1);
        smp(3'h0, 1'b0, 5'h00, 8'h3d, 6'h00, 1'b0);
        wr(8'h32, 8'h22);
        for (int i = 0; i <= IDLE_N + 1; i++)
            smp(3'h0, 1'b0, 5'h00, 8'h13, i > IDLE_N ? 6'h26 : 6'h00, i > IDLE_N);
        rdchk(8'h70, 8'h02);
        // interval code one needs more matching samples
        wr(8'h32, 8'h24);
        smp(3'h0, 1'b0, 5'h00, 8'h00, 6'h26, 1'b1);
        for (int i = 0; i <= IDLE_N1; i++)
            smp(3'h0, 1'b0, 5'h00, 8'h3d, i == IDLE_N1 ? 6'h26 : 6'h00, i == IDLE_N1);
        $display("idle test done");
    endtask
    task automatic t_mon;
        for (int c = 0; c < 16; c++)
        begin
            wr(8'h6f, 8'((c << 4) | (15 - c)));
            det <= 16'(1 << c);
            repeat (2) @(posedge clk);
            #1 chk(8'(mon_a), 8'h01);
            chk(8'(mon_b), 8'(c == 15 || c == 3 || c == 2));
        end
        wr(8'h6f, 8'hcd);
        tsel <= 5'h02;
        repeat (2) @(posedge clk);
        #1 chk(8'({mon_a, mon_b}), 8'h00);
        $display("monitor test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_actions;
        t_idle;
        t_mon;
        report_and_stop;
    end
    // the tests take well under a thousand cycles
    initial
    begin
        #80000;
        mismatches++;
        report_and_stop;
    end
endmodule
bind ecfx_ctrl ecfx_ctrl_monitor #(.CHW(CHW)) u_mon (.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_SAMPLE_VALID(I_SAMPLE_VALID), .I_CHAN(I_CHAN), .I_HOST_ONLY_CONTROL(I_HOST_ONLY_CONTROL),
    .I_HOST_DISABLE(I_HOST_DISABLE), .I_HOST_NLP_OFF(I_HOST_NLP_OFF), .I_HOST_FREEZE(I_HOST_FREEZE),
    .I_HOST_CONV_DISABLE(I_HOST_CONV_DISABLE), .I_DETECT(I_DETECT), .O_CTRL_VALID(O_CTRL_VALID),
    .O_CTRL_CHAN(O_CTRL_CHAN), .O_BYPASS(O_BYPASS), .O_NLP_OFF(O_NLP_OFF), .O_FREEZE(O_FREEZE),
    .O_METER_RESET(O_METER_RESET), .O_COEFF_RESET(O_COEFF_RESET), .O_CONV_DISABLE(O_CONV_DISABLE),
    .O_IDLE(O_IDLE), .O_MONITOR_PIN_A(O_MONITOR_PIN_A), .O_MONITOR_PIN_B(O_MONITOR_PIN_B));
`default_nettype wire
